// ==== verilog/jsd_pkg.sv ====
`default_nettype none
package jsd_pkg;
   // Register widths
   localparam int IR_W = 8;
   localparam int ID_W = 32;
   localparam int BSR_W = 113;
   localparam int NUM_BIDIR = 20;

   // Instruction codes
   localparam logic [IR_W-1:0] OP_EXTEST = 8'h00;
   localparam logic [IR_W-1:0] OP_SAMPLE = 8'h01;
   localparam logic [IR_W-1:0] OP_IDCODE = 8'h02;
   localparam logic [IR_W-1:0] OP_BYPASS = 8'hFF;
   localparam logic [IR_W-1:0] IR_CAPTURE = 8'h01;

   // Identification word layout
   localparam int ID_REV_LSB = 28;
   localparam int ID_PART_LSB = 12;
   localparam int ID_VEND_LSB = 1;
   localparam logic ID_FIX = 1'b1;

   // Reset values
   localparam logic TDO_RST = 1'b1;
   localparam logic [BSR_W-1:0] BSR_RST = '0;

   // Control cell of each bidirectional pin; its data cell follows it
   localparam int unsigned CTRL_CELL [NUM_BIDIR] = '{
      6, 9, 17, 19, 26, 29, 35, 37, 43, 45,
      66, 68, 74, 77, 83, 86, 93, 95, 103, 106};

   typedef enum logic [3:0] {
      TAP_TLR    = 4'hF,
      TAP_RTI    = 4'hC,
      TAP_SEL_DR = 4'h7,
      TAP_CAP_DR = 4'h6,
      TAP_SH_DR  = 4'h2,
      TAP_EX1_DR = 4'h1,
      TAP_PAU_DR = 4'h3,
      TAP_EX2_DR = 4'h0,
      TAP_UPD_DR = 4'h5,
      TAP_SEL_IR = 4'h4,
      TAP_CAP_IR = 4'hE,
      TAP_SH_IR  = 4'hA,
      TAP_EX1_IR = 4'h9,
      TAP_PAU_IR = 4'hB,
      TAP_EX2_IR = 4'h8,
      TAP_UPD_IR = 4'hD
   } jsd_tap_e;

   // One-cycle action strobes, plus the reset-state level
   typedef struct packed {
      logic tlr;
      logic cap_ir;
      logic sh_ir;
      logic upd_ir;
      logic cap_dr;
      logic sh_dr;
      logic upd_dr;
   } jsd_ctl_s;
endpackage : jsd_pkg
`default_nettype wire

// ==== verilog/jsd_scan_reg.sv ====
`timescale 1ns/10ps
`default_nettype none
module jsd_scan_reg
   import jsd_pkg::*;
#(
   parameter int W = 8,
   parameter logic [W-1:0] RST = '0
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Controls
   input wire logic clr_i,
   input wire logic cap_i,
   input wire logic sh_i,
   input wire logic upd_i,
   input wire logic [W-1:0] cap_val_i,
   input wire logic si_i,
   // Results
   output logic so_o,
   output logic [W-1:0] sh_o,
   output logic [W-1:0] par_o
);
   logic [W-1:0] sh_q, sh_d, par_q, par_d;

   always_comb begin
      sh_d = sh_q;
      par_d = par_q;
      if (clr_i) begin
         sh_d = RST;
         par_d = RST;
      end else begin
         if (cap_i) begin
            sh_d = cap_val_i;
         end else if (sh_i) begin
            sh_d = {si_i, sh_q[W-1:1]};
         end
         if (upd_i) begin
            par_d = sh_q;
         end
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sh_q <= RST;
         par_q <= RST;
      end else begin
         sh_q <= sh_d;
         par_q <= par_d;
      end
   end

   assign so_o = sh_q[0];
   assign sh_o = sh_q;
   assign par_o = par_q;
endmodule : jsd_scan_reg
`default_nettype wire

// ==== verilog/jsd_scan_data_regs.sv ====
`timescale 1ns/10ps
`default_nettype none
module jsd_scan_data_regs
   import jsd_pkg::*;
#(
   // Arbitrary identity values
   parameter logic [3:0] ID_REV = 4'h1,
   parameter logic [15:0] ID_PART = 16'h0ABC,
   parameter logic [10:0] ID_VENDOR = 11'h155
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Test access pins
   input wire logic tck_i,
   input wire logic tms_i,
   input wire logic tdi_i,
   input wire logic trst_n_i,
   output logic tdo_o,
   output logic tdo_oe_n_o,
   // Pin ring
   input wire logic [BSR_W-1:0] pin_ring_i,
   output logic [BSR_W-1:0] bsr_drive_o,
   output logic extest_o,
   output logic [NUM_BIDIR-1:0] bidir_oe_n_o
);
   localparam logic [ID_W-1:0] ID_WORD = {ID_REV, ID_PART, ID_VENDOR, ID_FIX};

   // Two-stage synchronisers; TCK is only a sampled signal here
   logic [3:0] pin_m_q, pin_s_q;
   logic [BSR_W-1:0] ring_m_q, ring_s_q;
   logic tck_prev_q;
   logic tck_s, tms_s, tdi_s, tap_rst, tck_rise, tck_fall;

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pin_m_q <= 4'h0;
         pin_s_q <= 4'h0;
         ring_m_q <= '0;
         ring_s_q <= '0;
         tck_prev_q <= 1'b0;
      end else begin
         pin_m_q <= {trst_n_i, tdi_i, tms_i, tck_i};
         pin_s_q <= pin_m_q;
         ring_m_q <= pin_ring_i;
         ring_s_q <= ring_m_q;
         tck_prev_q <= pin_s_q[0];
      end
   end

   assign tck_s = pin_s_q[0];
   assign tms_s = pin_s_q[1];
   assign tdi_s = pin_s_q[2];
   assign tap_rst = ~pin_s_q[3];
   assign tck_rise = tck_s & ~tck_prev_q;
   assign tck_fall = ~tck_s & tck_prev_q;

   // Test state machine
   jsd_tap_e state_q, state_d;

   always_comb begin
      state_d = state_q;
      if (tap_rst) begin
         state_d = TAP_TLR;
      end else if (tck_rise) begin
         unique case (state_q)
            TAP_TLR: state_d = tms_s ? TAP_TLR : TAP_RTI;
            TAP_RTI: state_d = tms_s ? TAP_SEL_DR : TAP_RTI;
            TAP_SEL_DR: state_d = tms_s ? TAP_SEL_IR : TAP_CAP_DR;
            TAP_CAP_DR: state_d = tms_s ? TAP_EX1_DR : TAP_SH_DR;
            TAP_SH_DR: state_d = tms_s ? TAP_EX1_DR : TAP_SH_DR;
            TAP_EX1_DR: state_d = tms_s ? TAP_UPD_DR : TAP_PAU_DR;
            TAP_PAU_DR: state_d = tms_s ? TAP_EX2_DR : TAP_PAU_DR;
            TAP_EX2_DR: state_d = tms_s ? TAP_UPD_DR : TAP_SH_DR;
            TAP_UPD_DR: state_d = tms_s ? TAP_SEL_DR : TAP_RTI;
            TAP_SEL_IR: state_d = tms_s ? TAP_TLR : TAP_CAP_IR;
            TAP_CAP_IR: state_d = tms_s ? TAP_EX1_IR : TAP_SH_IR;
            TAP_SH_IR: state_d = tms_s ? TAP_EX1_IR : TAP_SH_IR;
            TAP_EX1_IR: state_d = tms_s ? TAP_UPD_IR : TAP_PAU_IR;
            TAP_PAU_IR: state_d = tms_s ? TAP_EX2_IR : TAP_PAU_IR;
            TAP_EX2_IR: state_d = tms_s ? TAP_UPD_IR : TAP_SH_IR;
            TAP_UPD_IR: state_d = tms_s ? TAP_SEL_DR : TAP_RTI;
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_q <= TAP_TLR;
      end else begin
         state_q <= state_d;
      end
   end

   // Capture and shift on the rising edge, update on the falling edge
   jsd_ctl_s ctl;
   always_comb begin
      ctl.tlr = (state_q == TAP_TLR);
      ctl.cap_ir = tck_rise & (state_q == TAP_CAP_IR);
      ctl.sh_ir = tck_rise & (state_q == TAP_SH_IR);
      ctl.upd_ir = tck_fall & (state_q == TAP_UPD_IR);
      ctl.cap_dr = tck_rise & (state_q == TAP_CAP_DR);
      ctl.sh_dr = tck_rise & (state_q == TAP_SH_DR);
      ctl.upd_dr = tck_fall & (state_q == TAP_UPD_DR);
   end

   // Instruction register, preset while in test-logic-reset
   logic ir_so;
   logic [IR_W-1:0] ir_sh, ir_par;
   jsd_scan_reg #(.W(IR_W), .RST(OP_IDCODE)) u_ir (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .clr_i(ctl.tlr),
      .cap_i(ctl.cap_ir),
      .sh_i(ctl.sh_ir),
      .upd_i(ctl.upd_ir),
      .cap_val_i(IR_CAPTURE),
      .si_i(tdi_s),
      .so_o(ir_so),
      .sh_o(ir_sh),
      .par_o(ir_par)
   );

   // Unknown codes fall back to bypass so the chain stays one bit long
   logic sel_id, sel_bsr, sel_byp, sel_ext;
   assign sel_id = (ir_par == OP_IDCODE);
   assign sel_ext = (ir_par == OP_EXTEST);
   assign sel_bsr = sel_ext | (ir_par == OP_SAMPLE);
   assign sel_byp = ~sel_id & ~sel_bsr;

   // Boundary register over the whole pin ring
   logic bsr_so;
   logic [BSR_W-1:0] bsr_sh, bsr_par;
   jsd_scan_reg #(.W(BSR_W), .RST(BSR_RST)) u_bsr (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .clr_i(ctl.tlr),
      .cap_i(ctl.cap_dr & sel_bsr),
      .sh_i(ctl.sh_dr & sel_bsr),
      .upd_i(ctl.upd_dr & sel_bsr),
      .cap_val_i(ring_s_q),
      .si_i(tdi_s),
      .so_o(bsr_so),
      .sh_o(bsr_sh),
      .par_o(bsr_par)
   );

   // Bypass and identification registers
   logic byp_q, byp_d;
   logic [ID_W-1:0] id_q, id_d;

   always_comb begin
      byp_d = byp_q;
      id_d = id_q;
      if (ctl.cap_dr & sel_byp) begin
         byp_d = 1'b0;
      end else if (ctl.sh_dr & sel_byp) begin
         byp_d = tdi_s;
      end
      if (ctl.cap_dr & sel_id) begin
         id_d = ID_WORD;
      end else if (ctl.sh_dr & sel_id) begin
         id_d = {tdi_s, id_q[ID_W-1:1]};
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         byp_q <= 1'b0;
         id_q <= ID_WORD;
      end else begin
         byp_q <= byp_d;
         id_q <= id_d;
      end
   end

   // Output stage; TDO is only driven in the shift states
   logic tdo_q, tdo_d, tdo_oe_n_q, tdo_oe_n_d;
   logic extest_q, extest_d;
   logic [BSR_W-1:0] drive_q;
   logic [NUM_BIDIR-1:0] oe_n_q, oe_n_d;

   always_comb begin
      tdo_d = tdo_q;
      tdo_oe_n_d = tdo_oe_n_q;
      if (tck_fall) begin
         tdo_oe_n_d = 1'b1;
         if (state_q == TAP_SH_IR) begin
            tdo_d = ir_so;
            tdo_oe_n_d = 1'b0;
         end else if (state_q == TAP_SH_DR) begin
            tdo_d = sel_id ? id_q[0] : (sel_bsr ? bsr_so : byp_q);
            tdo_oe_n_d = 1'b0;
         end
      end
   end

   // Pin enables follow the update stage only under external test
   always_comb begin
      extest_d = sel_ext;
      for (int i = 0; i < NUM_BIDIR; i++) begin
         oe_n_d[i] = ~(sel_ext & bsr_par[CTRL_CELL[i]]);
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         tdo_q <= TDO_RST;
         tdo_oe_n_q <= 1'b1;
         extest_q <= 1'b0;
         drive_q <= BSR_RST;
         oe_n_q <= '1;
      end else begin
         tdo_q <= tdo_d;
         tdo_oe_n_q <= tdo_oe_n_d;
         extest_q <= extest_d;
         drive_q <= bsr_par;
         oe_n_q <= oe_n_d;
      end
   end

   assign tdo_o = tdo_q;
   assign tdo_oe_n_o = tdo_oe_n_q;
   assign extest_o = extest_q;
   assign bsr_drive_o = drive_q;
   assign bidir_oe_n_o = oe_n_q;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);

   a_ir_only_selected: assert property (
      (ir_sh != $past(ir_sh)) |-> $past(ctl.sh_ir | ctl.cap_ir | ctl.tlr))
      else $error("instruction shifted while not selected");
   a_tlr_preset: assert property (
      (state_q == TAP_TLR) |=> (ir_par == OP_IDCODE))
      else $error("instruction not preset in reset state");
   a_bypass_delay: assert property (
      (ctl.sh_dr && sel_byp) |=> (byp_q == $past(tdi_s)))
      else $error("bypass stage did not take TDI");
   a_bypass_clear: assert property (
      (ctl.cap_dr && sel_byp) |=> !byp_q)
      else $error("bypass stage not cleared at capture");
   a_id_capture: assert property (
      (ctl.cap_dr && sel_id) |=> (id_q == ID_WORD))
      else $error("identification word not captured");
   a_id_shift: assert property (
      (ctl.sh_dr && sel_id) |=> (id_q == {$past(tdi_s), $past(id_q[ID_W-1:1])}))
      else $error("identification register did not shift");
   a_id_fields: assert property (
      (ctl.cap_dr && sel_id) |=> (id_q[ID_W-1:ID_REV_LSB] == ID_REV)
         && (id_q[ID_REV_LSB-1:ID_PART_LSB] == ID_PART)
         && (id_q[ID_PART_LSB-1:ID_VEND_LSB] == ID_VENDOR) && id_q[0])
      else $error("identification fields wrong");
   a_bsr_capture: assert property (
      (ctl.cap_dr && sel_bsr) |=> (bsr_sh == $past(ring_s_q)))
      else $error("boundary register missed pin sample");
   a_bidir_hiz: assert property (
      (sel_ext && !bsr_par[CTRL_CELL[0]]) |=> bidir_oe_n_o[0])
      else $error("pin driven with control cell zero");
   a_tdo_on_fall: assert property (
      $changed(tdo_o) |-> $past(tck_fall))
      else $error("TDO moved off a falling edge");
   a_trst_reset: assert property (
      tap_rst |=> (state_q == TAP_TLR) [*2])
      else $error("test reset did not hold reset state");
   // Shift, instruction update, TDO and pin-enable checks, each one clock after its condition
   a_tdo_id_bit: assert property (
      (tck_fall && (state_q == TAP_SH_DR) && sel_id)
         |=> (tdo_o == $past(id_q[0])))
      else $error("identification bit not presented on TDO");
   a_byp_to_tdo: assert property (
      (tck_fall && (state_q == TAP_SH_DR) && sel_byp)
         |=> (tdo_o == $past(byp_q)))
      else $error("bypass stage not presented on TDO");
   a_bsr_shift: assert property (
      (ctl.sh_dr && sel_bsr)
         |=> (bsr_sh == {$past(tdi_s), $past(bsr_sh[BSR_W-1:1])}))
      else $error("boundary register did not shift");
   a_ir_update: assert property (
      ctl.upd_ir
         |=> (ir_par == $past(ir_sh)))
      else $error("instruction not taken at update");
   a_tdo_release: assert property (
      (tck_fall && (state_q != TAP_SH_DR) && (state_q != TAP_SH_IR))
         |=> tdo_oe_n_o)
      else $error("TDO left driven outside a shift state");
   a_bidir_drive: assert property (
      (sel_ext && bsr_par[CTRL_CELL[NUM_BIDIR-1]])
         |=> !bidir_oe_n_o[NUM_BIDIR-1])
      else $error("pin not driven with control cell one");
endmodule : jsd_scan_data_regs
`default_nettype wire

// ==== sim/jsd_tap_master.sv ====
`timescale 1ns/10ps
`default_nettype none
module jsd_tap_master (
   // Test access pins toward the device
   output logic tck_o,
   output logic tms_o,
   output logic tdi_o,
   output logic trst_n_o,
   // Serial data back from the device
   input wire logic tdo_i
);
   initial begin
      tck_o = 1'b0;
      tms_o = 1'b1;
      tdi_o = 1'b1;
      trst_n_o = 1'b0;
   end

   task automatic set_trst(input logic lvl);
      trst_n_o = lvl;
   endtask : set_trst

   // TCK stands low between calls; 62.5 ns halves give the 125 ns period
   task automatic cyc(input logic tms, input logic tdi, output logic tdo);
      tms_o = tms;
      tdi_o = tdi;
      #62.5 tck_o = 1'b1;
      tdo = tdo_i;
      #62.5 tck_o = 1'b0;
   endtask : cyc
endmodule : jsd_tap_master
`default_nettype wire

// ==== sim/tb_jtag_scan_data_registers.sv ====
`timescale 1ns/10ps
`default_nettype none
module tb_jtag_scan_data_registers;
   import jsd_pkg::*;
   // Arbitrary identity values
   localparam logic [31:0] ID_EXP = {4'h1, 16'h0ABC, 11'h155, 1'b1};
   logic clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic tck, tms, tdi, trst_n, tdo, tdo_oe_n, extest;
   logic tdo_line;
   logic [BSR_W-1:0] pins = '0;
   logic [BSR_W-1:0] drv;
   logic [NUM_BIDIR-1:0] oe_n;
   logic [127:0] din, dout;
   logic [7:0] op;
   int n_mismatch = 0;
   int tests_run = 0;
   integer seed = 32'h58f79dd4;

   always #5 clk_i = ~clk_i;

   // A released TDO shows the opposite level, so a late enable is caught
   assign tdo_line = tdo_oe_n ? ~tdo : tdo;

   jsd_scan_data_regs DUT (
      .clk_i(clk_i), .rst_n_i(rst_n_i), .tck_i(tck), .tms_i(tms),
      .tdi_i(tdi), .trst_n_i(trst_n), .tdo_o(tdo), .tdo_oe_n_o(tdo_oe_n),
      .pin_ring_i(pins), .bsr_drive_o(drv), .extest_o(extest),
      .bidir_oe_n_o(oe_n));

   jsd_tap_master u_host (.tck_o(tck), .tms_o(tms), .tdi_o(tdi),
      .trst_n_o(trst_n), .tdo_i(tdo_line));

   task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask : chk

   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : print_verdict

   task automatic step(input logic m);
      logic t;
      u_host.cyc(m, 1'b1, t);
   endtask : step

   // From run-test-idle through one IR or DR scan and back to idle
   task automatic scan(input bit ir, input int n);
      logic t;
      step(1'b1);
      if (ir) step(1'b1);
      step(1'b0);
      step(1'b0);
      for (int i = 0; i < n; i++) begin
         u_host.cyc(i == n - 1, din[i], t);
         dout[i] = t;
         if (i == 0) chk(128'(tdo_oe_n), 128'h0);
      end
      step(1'b1);
      step(1'b0);
   endtask : scan

   function automatic logic [127:0] rnd();
      return {$random(seed), $random(seed), $random(seed), $random(seed)};
   endfunction : rnd

   // A zero control cell leaves its pin's driver off
   function automatic logic [NUM_BIDIR-1:0] exp_oe(input logic [127:0] d);
      logic [NUM_BIDIR-1:0] r;
      for (int k = 0; k < NUM_BIDIR; k++) r[k] = ~d[CTRL_CELL[k]];
      return r;
   endfunction : exp_oe

   initial begin
      #1ms;
      n_mismatch++;
      print_verdict();
   end

   initial begin
      repeat (10) @(posedge clk_i);
      @(negedge clk_i);
      rst_n_i = 1'b1;
      #3;
      u_host.set_trst(1'b1);
      repeat (3) step(1'b0);
      din = rnd();
      scan(1'b0, 32);
      chk(128'(dout[31:0]), 128'(ID_EXP));
      chk(128'(tdo_oe_n), 128'h1);
      // Bypass code first, then codes that no instruction claims
      for (int k = 0; k < 4; k++) begin
         din = rnd();
         op = (k == 0) ? OP_BYPASS : (8'h80 | din[7:0]);
         din = {120'h0, op};
         scan(1'b1, 8);
         chk(128'(dout[7:0]), 128'(IR_CAPTURE));
         din = rnd();
         scan(1'b0, 20);
         chk(128'(dout[19:0]), 128'({din[18:0], 1'b0}));
      end
      din = rnd();
      pins = din[BSR_W-1:0];
      din = {120'h0, OP_SAMPLE};
      scan(1'b1, 8);
      din = rnd();
      scan(1'b0, BSR_W);
      chk(128'(dout[BSR_W-1:0]), 128'(pins));
      din = {120'h0, OP_EXTEST};
      scan(1'b1, 8);
      chk(128'(extest), 128'h1);
      for (int k = 0; k < 3; k++) begin
         din = (k == 0) ? rnd() : ((k == 1) ? '1 : '0);
         scan(1'b0, BSR_W);
         chk(128'(drv), 128'(din[BSR_W-1:0]));
         chk(128'(oe_n), 128'(exp_oe(din)));
      end
      // Test reset in mid-run must restore identification read
      u_host.set_trst(1'b0);
      repeat (2) step(1'b0);
      chk(128'(extest), 128'h0);
      chk(128'(drv), 128'h0);
      chk(128'(oe_n), 128'({NUM_BIDIR{1'b1}}));
      u_host.set_trst(1'b1);
      repeat (2) step(1'b0);
      din = rnd();
      scan(1'b0, 32);
      chk(128'(dout[31:0]), 128'(ID_EXP));
      print_verdict();
   end
endmodule : tb_jtag_scan_data_registers
`default_nettype wire
